//--- shared/itc_defines.vh
// register map, field positions, reset values and timing counts
`ifndef ITC_DEFINES_VH
`define ITC_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets (printed offsets are indices, byte = 4x)
// ---------------------------------------------------------------
`define ITC_IDX_TIMER_CFG     8'h31
`define ITC_IDX_CLKOUT_CFG    8'h32
`define ITC_IDX_STATUS_CTL    8'hFF
`define ITC_ADDR_TIMER_CFG    12'h0C4
`define ITC_ADDR_CLKOUT_CFG   12'h0C8
`define ITC_ADDR_STATUS_CTL   12'h3FC
`define ITC_ADDR_RELOAD_LO    12'h400
`define ITC_ADDR_RELOAD_HI    12'h404
`define ITC_ADDR_COUNT        12'h408
`define ITC_ADDR_IRQ_STATUS   12'h40C
`define ITC_ADDR_IRQ_CLEAR    12'h410
`define ITC_ADDR_IRQ_ENABLE   12'h414
`define ITC_ADDR_CPU_CLK_CFG  12'h418

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ITC_RST_TIMER_CFG     8'h8F
`define ITC_RST_CLKOUT_CFG    8'h00
`define ITC_RST_STATUS_POR    8'h10
`define ITC_RST_RELOAD        12'h000
`define ITC_RST_CPU_DIV       3'h7

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ITC_SCR_WATCHDOG_RESET_FLAG          5
`define ITC_SCR_POWER_ON_RESET_FLAG          4
`define ITC_SCR_SLEEP         3
`define ITC_SCR_STOP          0

// ---------------------------------------------------------------
// source select codes
// ---------------------------------------------------------------
`define ITC_SRC_INT24         2'h0
`define ITC_SRC_EXT           2'h1
`define ITC_SRC_LP32          2'h2
`define ITC_SRC_CAP           2'h3

// ---------------------------------------------------------------
// timing: oscillator recovery in low-power cycles
// ---------------------------------------------------------------
`define ITC_WAKE_LP_CYCLES    2'h3

`endif

//--- rtl/itc_interval_timer.v
// interval timer with clock prescalers, clock-out select and reset status
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
// How it works
// - interval source: external, 24 MHz, 32 kHz or capture clock
// - interval prescaler divides by one, two, three or four
// - 12-bit down counter restarted from software reload register
// - at zero the next timer tick loads reload instead of counting
// - reload readable and writable while running; software avoids split writes
// - interrupt request raised on every reload
// - capture source: external, 24 MHz or 32 kHz oscillator
// - capture prescaler divides by two, four, six or eight
// - sleep entry forces processor clock to internal oscillator, stops it
// - wake runs internal oscillator, usable after three 32 kHz cycles
// - power-on or watchdog reset restores defaults, disables interrupts
// - separate power-on and watchdog flags record reset cause
// - processor fetches from address zero after any reset
// - internal clocking mode active after reset until changed
// - power-on processor clock is 24 MHz divided by eight
// - power-on loads status with only the power-on flag set
// - power-on flag set by hardware, clearable but not settable
`include "itc_defines.vh"

module itc_interval_timer #(
    parameter CNT_W = 12
) (
    input  wire        clk_sys_i,
    input  wire        rst_i,
    input  wire        por_i,
    input  wire        watchdog_reset_i,
    input  wire        osc24_tick_i,
    input  wire        ext_tick_i,
    input  wire        lp32_tick_i,
    input  wire        osc24_lvl_i,
    input  wire        ext_lvl_i,
    input  wire        lp32_lvl_i,
    input  wire        sleep_entry_i,
    input  wire        wake_i,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    output wire        irq_o,
    output reg         clock_output_o,
    output reg         osc24_run_o,
    output reg         osc_ready_o,
    output reg         cpu_clk_sel_ext_o,
    output reg  [2:0]  cpu_clk_div_o,
    output reg         cpu_reset_o,
    output wire [15:0] fetch_addr_o
);

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    reg  [7:0]       timer_cfg;
    reg  [1:0]       clock_output_select;
    reg              watchdog_reset_flag;
    reg              power_on_reset_flag;
    reg              sleep_bit;
    reg              stop_bit;
    reg  [CNT_W-1:0] interval_reload_register;
    reg  [CNT_W-1:0] interval_down_timer;
    reg              irq_status;
    reg              irq_enable;
    reg  [2:0]       cap_cnt;
    reg  [1:0]       itv_cnt;
    reg  [1:0]       wake_cnt;
    reg              waking;
    reg              capture_timer_clock;

    wire             any_reset = rst_i | por_i | watchdog_reset_i;
    wire             wr = psel & penable & pwrite;
    wire             rd = psel & penable & ~pwrite;
    wire             mapped;

    assign pready  = 1'b1;   // zero wait states
    assign pslverr = psel & penable & ~mapped;
    assign fetch_addr_o = 16'h0000;

    // ---------------------------------------------------------------
    // capture clock: select and divide by 2/4/6/8
    // ---------------------------------------------------------------
    reg cap_src_tick;
    always @* begin
        case (timer_cfg[5:4])
            `ITC_SRC_INT24: cap_src_tick = osc24_tick_i;
            `ITC_SRC_EXT:   cap_src_tick = ext_tick_i;
            `ITC_SRC_LP32:  cap_src_tick = lp32_tick_i;
            default:        cap_src_tick = 1'b0;
        endcase
    end

    // half period is (field+1) source ticks, so full divide is 2..8
    wire cap_half_done = cap_src_tick & (cap_cnt[1:0] == timer_cfg[7:6]);
    wire cap_tick = cap_half_done & capture_timer_clock;
    always @(posedge clk_sys_i) begin
        if (any_reset) begin
            cap_cnt             <= 3'h0;
            capture_timer_clock <= 1'b0;
        end else if (cap_half_done) begin
            cap_cnt             <= 3'h0;
            capture_timer_clock <= ~capture_timer_clock;
        end else if (cap_src_tick) begin
            cap_cnt <= cap_cnt + 3'h1;
        end
    end

    // ---------------------------------------------------------------
    // interval clock: select and divide by 1..4
    // ---------------------------------------------------------------
    reg itv_src_tick;
    always @* begin
        case (timer_cfg[1:0])
            `ITC_SRC_INT24: itv_src_tick = osc24_tick_i;
            `ITC_SRC_EXT:   itv_src_tick = ext_tick_i;
            `ITC_SRC_LP32:  itv_src_tick = lp32_tick_i;
            default:        itv_src_tick = cap_tick;
        endcase
    end

    wire interval_timer_clock = itv_src_tick & (itv_cnt == timer_cfg[3:2]);
    always @(posedge clk_sys_i) begin
        if (any_reset)
            itv_cnt <= 2'h0;
        else if (interval_timer_clock)
            itv_cnt <= 2'h0;
        else if (itv_src_tick)
            itv_cnt <= itv_cnt + 2'h1;
    end

    // ---------------------------------------------------------------
    // down counter with reload
    // ---------------------------------------------------------------
    wire reload_evt = interval_timer_clock &&
                      interval_down_timer == {CNT_W{1'b0}};
    always @(posedge clk_sys_i) begin
        if (any_reset)
            interval_down_timer <= `ITC_RST_RELOAD;
        else if (reload_evt)
            interval_down_timer <= interval_reload_register;
        else if (interval_timer_clock)
            interval_down_timer <= interval_down_timer - 1'b1;
    end

    // reload halves written separately; no shadowing, software's job
    always @(posedge clk_sys_i) begin
        if (any_reset) begin
            interval_reload_register <= `ITC_RST_RELOAD;
        end else if (wr && paddr == `ITC_ADDR_RELOAD_LO) begin
            interval_reload_register[7:0] <= pwdata[7:0];
        end else if (wr && paddr == `ITC_ADDR_RELOAD_HI) begin
            interval_reload_register[CNT_W-1:8] <= pwdata[CNT_W-9:0];
        end
    end

    // ---------------------------------------------------------------
    // interrupt: sticky status, set wins over clear
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (any_reset) begin
            irq_status <= 1'b0;
            irq_enable <= 1'b0;
        end else begin
            if (reload_evt)
                irq_status <= 1'b1;
            else if (wr && paddr == `ITC_ADDR_IRQ_CLEAR && pwdata[0])
                irq_status <= 1'b0;
            if (wr && paddr == `ITC_ADDR_IRQ_ENABLE)
                irq_enable <= pwdata[0];
        end
    end
    assign irq_o = irq_status & irq_enable;

    // ---------------------------------------------------------------
    // config and status registers
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (any_reset) begin
            timer_cfg           <= `ITC_RST_TIMER_CFG;
            clock_output_select <= 2'h0;
            sleep_bit           <= 1'b0;
            stop_bit            <= 1'b0;
        end else begin
            if (wr && paddr == `ITC_ADDR_TIMER_CFG)
                timer_cfg <= pwdata[7:0];
            if (wr && paddr == `ITC_ADDR_CLKOUT_CFG)
                clock_output_select <= pwdata[1:0];
            if (wake_i)
                sleep_bit <= 1'b0;
            else if (wr && paddr == `ITC_ADDR_STATUS_CTL)
                sleep_bit <= pwdata[`ITC_SCR_SLEEP];
            if (wr && paddr == `ITC_ADDR_STATUS_CTL)
                stop_bit <= pwdata[`ITC_SCR_STOP];
        end
    end

    // reset flags: por/watchdog set, software clears by writing 1
    always @(posedge clk_sys_i) begin
        if (por_i | rst_i) begin
            power_on_reset_flag <= 1'b1;
            watchdog_reset_flag <= 1'b0;
        end else if (watchdog_reset_i) begin
            watchdog_reset_flag <= 1'b1;
        end else if (wr && paddr == `ITC_ADDR_STATUS_CTL) begin
            // only a clear is possible; writing 0 leaves a flag alone
            if (pwdata[`ITC_SCR_POWER_ON_RESET_FLAG])
                power_on_reset_flag <= 1'b0;
            if (pwdata[`ITC_SCR_WATCHDOG_RESET_FLAG])
                watchdog_reset_flag <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // processor clock, sleep and wake
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (any_reset) begin
            cpu_clk_sel_ext_o <= 1'b0;
            cpu_clk_div_o     <= `ITC_RST_CPU_DIV;
            osc24_run_o       <= 1'b1;
            osc_ready_o       <= 1'b1;
            waking            <= 1'b0;
            wake_cnt          <= 2'h0;
        end else if (sleep_entry_i) begin
            cpu_clk_sel_ext_o <= 1'b0;
            osc24_run_o       <= 1'b0;
            osc_ready_o       <= 1'b0;
            waking            <= 1'b0;
        end else if (wake_i) begin
            osc24_run_o <= 1'b1;
            waking      <= 1'b1;
            wake_cnt    <= 2'h0;
        end else if (waking) begin
            if (lp32_tick_i && wake_cnt == `ITC_WAKE_LP_CYCLES - 2'h1) begin
                waking      <= 1'b0;
                osc_ready_o <= 1'b1;
            end else if (lp32_tick_i) begin
                wake_cnt <= wake_cnt + 2'h1;
            end
        end else if (wr && paddr == `ITC_ADDR_CPU_CLK_CFG) begin
            // external choice is not restored on wake
            cpu_clk_sel_ext_o <= pwdata[0];
            cpu_clk_div_o     <= pwdata[6:4];
        end
    end

    // ---------------------------------------------------------------
    // clock output mux, registered
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            clock_output_o <= 1'b0;
            cpu_reset_o    <= 1'b1;
        end else begin
            cpu_reset_o <= por_i | watchdog_reset_i;
            case (clock_output_select)
                2'h0:    clock_output_o <= osc24_lvl_i;
                2'h1:    clock_output_o <= ext_lvl_i;
                2'h2:    clock_output_o <= lp32_lvl_i;
                default: clock_output_o <= osc24_lvl_i & osc24_run_o;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // read mux, registered data lags nothing: pready is always high
    // ---------------------------------------------------------------
    reg [31:0] rd_val;
    reg        hit;
    always @* begin
        rd_val = 32'h0000_0000;
        hit    = 1'b1;
        case (paddr)
            `ITC_ADDR_TIMER_CFG:   rd_val[7:0] = timer_cfg;
            `ITC_ADDR_CLKOUT_CFG:  rd_val[1:0] = clock_output_select;
            `ITC_ADDR_STATUS_CTL:  rd_val[7:0] = {2'b00,
                                       watchdog_reset_flag,
                                       power_on_reset_flag, sleep_bit,
                                       2'b00, stop_bit};
            `ITC_ADDR_RELOAD_LO:   rd_val[7:0] = interval_reload_register[7:0];
            `ITC_ADDR_RELOAD_HI:   rd_val[CNT_W-9:0] =
                                       interval_reload_register[CNT_W-1:8];
            `ITC_ADDR_COUNT:       rd_val[CNT_W-1:0] = interval_down_timer;
            `ITC_ADDR_IRQ_STATUS:  rd_val[0] = irq_status;
            `ITC_ADDR_IRQ_CLEAR:   rd_val = 32'h0000_0000;
            `ITC_ADDR_IRQ_ENABLE:  rd_val[0] = irq_enable;
            `ITC_ADDR_CPU_CLK_CFG: rd_val[6:0] = {cpu_clk_div_o, 3'b000,
                                       cpu_clk_sel_ext_o};
            default:               hit = 1'b0;
        endcase
    end
    assign mapped = hit;

    // data output from a flip-flop, loaded on the setup cycle
    always @(posedge clk_sys_i) begin
        if (rst_i)
            prdata <= 32'h0000_0000;
        else if (psel & ~penable & ~pwrite)
            prdata <= rd_val;
    end

endmodule

//--- test/itc_interval_timer_assertions.sv
// port checker for the interval timer block
`timescale 1ns/1ps
`include "itc_defines.vh"
module itc_chk (
    input wire        clk_sys_i,
    input wire        rst_i,
    input wire        por_i,
    input wire        watchdog_reset_i,
    input wire        osc24_lvl_i,
    input wire        ext_lvl_i,
    input wire        lp32_lvl_i,
    input wire        lp32_tick_i,
    input wire        sleep_entry_i,
    input wire        wake_i,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pslverr,
    input wire        irq_o,
    input wire        clock_output_o,
    input wire        osc24_run_o,
    input wire        osc_ready_o,
    input wire        cpu_clk_sel_ext_o,
    input wire [2:0]  cpu_clk_div_o,
    input wire [15:0] fetch_addr_o
);
    // ------------------------------------------------
    // snooped clock-out select and wake tick count
    // ------------------------------------------------
    reg  [1:0] sel;
    reg  [1:0] lp_n;
    reg        any_q;
    wire       anyr  = rst_i | por_i | watchdog_reset_i;
    wire       wr_co = psel & penable & pwrite
                       & (paddr == `ITC_ADDR_CLKOUT_CFG);
    wire       lvl   = (sel == 2'h0) ? osc24_lvl_i :
                       (sel == 2'h1) ? ext_lvl_i : lp32_lvl_i;
    wire       map   = paddr inside {`ITC_ADDR_TIMER_CFG,
        `ITC_ADDR_CLKOUT_CFG, `ITC_ADDR_STATUS_CTL, `ITC_ADDR_RELOAD_LO,
        `ITC_ADDR_RELOAD_HI, `ITC_ADDR_COUNT, `ITC_ADDR_IRQ_STATUS,
        `ITC_ADDR_IRQ_CLEAR, `ITC_ADDR_IRQ_ENABLE, `ITC_ADDR_CPU_CLK_CFG};

    // reset wins over a write, so a late write never leaks past it
    always @(posedge clk_sys_i) begin
        any_q <= anyr;
        if (anyr)
            sel <= 2'h0;
        else if (wr_co)
            sel <= pwdata[1:0];
        if (wake_i || sleep_entry_i)
            lp_n <= 2'h0;
        else if (lp32_tick_i && lp_n != 2'h3)
            lp_n <= lp_n + 2'h1;
    end

    default clocking dc @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    AST_FETCH:
        assert property (fetch_addr_o == 16'h0000)
        else $error("fetch address not zero");
    AST_RST_IRQ:
        assert property ((por_i || watchdog_reset_i) |=> !irq_o)
        else $error("interrupt live after reset");
    AST_RST_DIV:
        assert property ((por_i || watchdog_reset_i) |=>
            cpu_clk_div_o == 3'h7 && !cpu_clk_sel_ext_o)
        else $error("processor clock default wrong");
    AST_SLEEP:
        assert property (sleep_entry_i && !psel |=>
            !cpu_clk_sel_ext_o && !osc24_run_o)
        else $error("sleep did not force internal clock");
    AST_WAKE_SEL:
        assert property (wake_i && !psel |=> !cpu_clk_sel_ext_o)
        else $error("wake not on internal clock");
    AST_WAKE_RDY:
        assert property ($rose(osc_ready_o) && !any_q |-> lp_n == 2'h3)
        else $error("oscillator ready without three slow ticks");
    AST_SLVERR:
        assert property (psel && penable |-> pslverr == !map)
        else $error("error response wrong for address");
    AST_CLKOUT:
        assert property (!anyr && sel != 2'h3 |=>
            clock_output_o == $past(lvl))
        else $error("clock output follows wrong source");

    COV_IRQ: cover property ($rose(irq_o));
    COV_ERR: cover property (psel && penable && pslverr);
    COV_RDY: cover property ($rose(osc_ready_o) && !any_q);
endmodule

bind itc_interval_timer itc_chk u_chk (.*);

//--- test/itc_interval_timer_tb.sv
// self-checking bench for the interval timer block
`timescale 1ns/1ps
`include "itc_defines.vh"
module itc_interval_timer_tb;
    // ------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------
    reg         clk_sys_i, rst_i, por_i, watchdog_reset_i, wake_i;
    reg         osc24_tick_i, ext_tick_i, lp32_tick_i, sleep_entry_i;
    reg         osc24_lvl_i, ext_lvl_i, lp32_lvl_i, psel, penable;
    reg         pwrite, serr, irq_q;
    reg  [11:0] paddr, rv;
    reg  [31:0] pwdata, rdata, st, t_last, t_prev, cyc;
    reg  [1:0]  ph, d, f, s, cs;
    wire        pready, pslverr, irq_o, clock_output_o;
    wire        osc24_run_o, osc_ready_o, cpu_clk_sel_ext_o;
    wire [31:0] prdata;
    wire [2:0]  cpu_clk_div_o;
    wire [15:0] fetch_addr_o;
    wire        cpu_reset_o;
    integer     n_fail, checks, n_rise, i, k, n;

    itc_interval_timer dut (.*);

    always #2.5 clk_sys_i = ~clk_sys_i;

    // xorshift, the fixed start keeps every run identical
    function [31:0] rnd;
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        rnd = st;
    endfunction

    // every source ticks once in three cycles
    function [31:0] exp_per(input [11:0] r, input [1:0] dv, sr, fv);
        exp_per = 3 * (r + 1) * (dv + 1) * (sr == 2'h3 ? 2 * (fv + 1) : 1);
    endfunction

    task chk(input [31:0] got, input [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // setup, then access held until pready is seen high
    task apb(input w, input [11:0] a, input [31:0] dt);
        integer j;
        @(posedge clk_sys_i);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= dt;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        @(posedge clk_sys_i);
        for (j = 0; j < 50 && pready !== 1'b1; j = j + 1)
            @(posedge clk_sys_i);
        if (j == 50)
            n_fail = n_fail + 1;   // no answer counts as a mismatch
        rdata = prdata;
        serr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input [11:0] a, input [31:0] dt);
        apb(1'b1, a, dt);
    endtask

    task rd(input [11:0] a, input [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask

    // clear first: a line left high would hide the next edge
    task irq_ack;
        wr(`ITC_ADDR_IRQ_CLEAR, 32'h1);
        n = n_rise;
        for (k = 0; k < 4000 && n_rise == n; k = k + 1)
            @(posedge clk_sys_i);
        if (k == 4000)
            n_fail = n_fail + 1;   // lost reload counts as a mismatch
    endtask

    task test_done;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // source ticks, random levels, interrupt edge stamps
    always @(posedge clk_sys_i) begin
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        osc24_tick_i <= (ph == 2'h0);
        ext_tick_i   <= (ph == 2'h1);
        lp32_tick_i  <= (ph == 2'h2);
        void'(rnd());
        {osc24_lvl_i, ext_lvl_i, lp32_lvl_i} <= st[2:0];
        cyc   <= cyc + 32'h1;
        irq_q <= irq_o;
        if (irq_o === 1'b1 && irq_q === 1'b0) begin
            t_prev <= t_last;
            t_last <= cyc;
            n_rise <= n_rise + 1;
        end
    end

    initial begin
        clk_sys_i = 1'b0;
        rst_i = 1'b1;
        {por_i, watchdog_reset_i, sleep_entry_i, wake_i, irq_q} = 5'h0;
        {psel, penable, pwrite, paddr, pwdata} = 47'h0;
        {osc24_tick_i, ext_tick_i, lp32_tick_i, ph} = 5'h0;
        {osc24_lvl_i, ext_lvl_i, lp32_lvl_i} = 3'h0;
        {n_fail, checks, n_rise, cyc, t_last, t_prev} = '0;
        st = 32'h000110A2;
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(`ITC_ADDR_TIMER_CFG, 32'h8F);
        rd(`ITC_ADDR_STATUS_CTL, 32'h10);
        rd(`ITC_ADDR_CPU_CLK_CFG, 32'h70);
        chk({16'h0, fetch_addr_o}, 32'h0);
        chk({31'h0, osc24_run_o}, 32'h1);
        apb(1'b0, 12'h0F0, 32'h0);
        chk({31'h0, serr}, 32'h1);
        chk(rdata, 32'h0);
        wr(`ITC_ADDR_STATUS_CTL, 32'h10);
        rd(`ITC_ADDR_STATUS_CTL, 32'h0);
        wr(`ITC_ADDR_STATUS_CTL, 32'h30);
        rd(`ITC_ADDR_STATUS_CTL, 32'h0);
        // each clock-out code; the checker follows the mux for codes 0 to 2
        for (i = 0; i < 4; i = i + 1) begin
            wr(`ITC_ADDR_CLKOUT_CFG, i);
            rd(`ITC_ADDR_CLKOUT_CFG, i);
            repeat (8) @(posedge clk_sys_i);
        end
        // reload periods over sources, dividers and reload values
        wr(`ITC_ADDR_IRQ_ENABLE, 32'h1);
        for (i = 0; i < 8; i = i + 1) begin
            void'(rnd());
            rv = (i == 0) ? 12'h103 : 12'h004 + {8'h00, st[3:0]};
            s  = i[1:0];
            d  = (i == 0) ? 2'h0 : st[5:4];
            f  = st[7:6];
            cs = (st[9:8] == 2'h3) ? 2'h0 : st[9:8];
            wr(`ITC_ADDR_RELOAD_LO, {24'h0, rv[7:0]});
            wr(`ITC_ADDR_RELOAD_HI, {28'h0, rv[11:8]});
            wr(`ITC_ADDR_TIMER_CFG, {24'h0, f, cs, d, s});
            rd(`ITC_ADDR_RELOAD_HI, {28'h0, rv[11:8]});
            irq_ack;
            irq_ack;
            irq_ack;
            chk(t_last - t_prev, exp_per(rv, d, s, f));
            apb(1'b0, `ITC_ADDR_COUNT, 32'h0);
            chk({31'h0, rdata <= rv}, 32'h1);
        end
        // a masked event keeps the line low
        wr(`ITC_ADDR_IRQ_ENABLE, 32'h0);
        wr(`ITC_ADDR_TIMER_CFG, 32'h0);
        repeat (100) @(posedge clk_sys_i);
        chk({31'h0, irq_o}, 32'h0);
        wr(`ITC_ADDR_IRQ_ENABLE, 32'h1);
        @(negedge clk_sys_i);
        chk({31'h0, irq_o}, 32'h1);
        @(posedge clk_sys_i);
        watchdog_reset_i <= 1'b1;
        @(posedge clk_sys_i);
        watchdog_reset_i <= 1'b0;
        @(negedge clk_sys_i);
        chk({31'h0, irq_o}, 32'h0);
        rd(`ITC_ADDR_STATUS_CTL, 32'h20);
        rd(`ITC_ADDR_TIMER_CFG, 32'h8F);
        // sleep drops the external choice; wake needs three slow ticks
        wr(`ITC_ADDR_CPU_CLK_CFG, 32'h71);
        @(posedge clk_sys_i);
        sleep_entry_i <= 1'b1;
        @(posedge clk_sys_i);
        sleep_entry_i <= 1'b0;
        @(negedge clk_sys_i);
        chk({30'h0, cpu_clk_sel_ext_o, osc24_run_o}, 32'h0);
        @(posedge clk_sys_i);
        while (ph != 2'h0)
            @(posedge clk_sys_i);
        wake_i <= 1'b1;
        @(posedge clk_sys_i);
        wake_i <= 1'b0;
        n = 0;
        for (k = 0; k < 60 && osc_ready_o !== 1'b1; k = k + 1) begin
            @(posedge clk_sys_i);
            n = n + lp32_tick_i;
        end
        chk(n, 32'h3);
        chk({31'h0, cpu_clk_sel_ext_o}, 32'h0);
        wr(`ITC_ADDR_CPU_CLK_CFG, 32'h71);
        @(negedge clk_sys_i);
        chk({31'h0, cpu_clk_sel_ext_o}, 32'h1);
        @(posedge clk_sys_i);
        por_i <= 1'b1;
        @(posedge clk_sys_i);
        por_i <= 1'b0;
        @(negedge clk_sys_i);
        chk({31'h0, cpu_reset_o}, 32'h1);
        rd(`ITC_ADDR_STATUS_CTL, 32'h10);
        rd(`ITC_ADDR_CPU_CLK_CFG, 32'h70);
        test_done;
    end

    // hang guard, far above the longest expected run
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        n_fail = n_fail + 1;
        test_done;
    end
endmodule
